// ===== rsc_refresh_sleep_config.sv
// Configuration word for refresh region, sleep and clock type, with the
// self-refresh scheduler and the strobe latency request it governs.
// Assumes cfgWr comes from ref_clk logic; select and link clocks are pins.
`timescale 1ns/1ps

module rsc_refresh_sleep_config
  import rsc_pkg::*;
#(
  parameter int ROW_W = 8,
  parameter bit HOT_PART = 1'b0,
  parameter int INTERVAL_CYC = (HOT_PART ? INTERVAL_1US_NS : INTERVAL_4US_NS)
                               * CLK_MHZ / 1000 / (1 << ROW_W)
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic inverted_clock_input,
  input wire logic chipSelect_b,
  input wire logic addrPhase,
  input wire rsc_wr_type cfgWr,
  output rsc_stat_type status,
  output logic diffClkEn,
  output logic linkClkSample,
  output logic [ROW_W-1:0] refreshRow,
  output logic refreshStrobe,
  output logic read_write_data_strobe_o,
  output logic read_write_data_strobe_oe_b
);

  // ************************************************************
  // Elaboration checks.
  // ************************************************************
  // The region decode needs an eighth of the rows to be at least one row.
  if (ROW_W < 3)
  begin : g_bad_row_w
    $error("rsc: ROW_W must be at least 3");
  end

  // A zero interval would leave the timer with no terminal count.
  if (INTERVAL_CYC < 1)
  begin : g_bad_interval
    $error("rsc: INTERVAL_CYC must be at least 1");
  end

  // The busy counter is three bits wide.
  if (REFRESH_BUSY_CYC < 1 || REFRESH_BUSY_CYC > 8)
  begin : g_bad_busy
    $error("rsc: REFRESH_BUSY_CYC must lie between 1 and 8");
  end

  typedef enum logic [2:0] {
    RF_IDLE = 3'b001,
    RF_WAIT = 3'b010,
    RF_BUSY = 3'b100
  } rsc_rf_type;

  // ************************************************************
  // Pin synchronisers into ref_clk.
  // ************************************************************
  logic csMeta_r, csSync_r, csPrev_r, apMeta_r, apSync_r;

  // Two flops per pin, plus a third on select for the edge detector; only the flops after the first feed any logic.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      csMeta_r <= 1'b1;
      csSync_r <= 1'b1;
      csPrev_r <= 1'b1;
      apMeta_r <= 1'b0;
      apSync_r <= 1'b0;
    end
    else
    begin
      csMeta_r <= chipSelect_b;
      csSync_r <= csMeta_r;
      csPrev_r <= csSync_r;
      apMeta_r <= addrPhase;
      apSync_r <= apMeta_r;
    end
  end

  // Select idles high, so the edge detector resets high and sees no false
  // fall straight after reset.
  wire csFall = csPrev_r & ~csSync_r;
  wire accessActive = ~csSync_r;

  // ************************************************************
  // Configuration word.
  // ************************************************************
  logic clkType_r, sleep_r;
  logic [2:0] partial_r;
  logic [8:0] rsv_r;
  logic [1:0] intervalCode;

  assign intervalCode = HOT_PART ? INTERVAL_1US : INTERVAL_4US;

  // Wake on falling select wins over a simultaneous write of the sleep bit,
  // since the host is already addressing the array.
  wire sleepNxt = csFall ? 1'b0
                : cfgWr.wrEn ? cfgWr.wrData[SLEEP_BIT]
                : sleep_r;

  // Synchronous reset returns defaults and leaves sleep.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      clkType_r <= CLK_TYPE_RESET;
      sleep_r <= 1'b0;
      partial_r <= PAR_RESET;
      rsv_r <= RSV_RESET;
    end
    else
    begin
      sleep_r <= sleepNxt;
      if (cfgWr.wrEn)
      begin
        clkType_r <= cfgWr.wrData[CLK_TYPE_BIT];
        partial_r <= cfgWr.wrData[PAR_HI:PAR_LO];
        rsv_r <= cfgWr.wrData[CFG_W-1:RSV_LO];
      end
    end
  end

  // ************************************************************
  // Region limits for partial refresh.
  // ************************************************************
  logic [ROW_W-1:0] rowBase, rowMask;
  localparam logic [ROW_W-1:0] ALL_ROWS = '1;

  // Size from the low two code bits, side from the top bit.
  always_comb
  begin
    rowMask = ALL_ROWS;
    if (partial_r[1:0] != 2'h0)
      rowMask = ALL_ROWS >> partial_r[1:0];
    rowBase = '0;
    if (partial_r[2] && partial_r[1:0] != 2'h0)
      rowBase = ~rowMask;
  end

  // Code 100 or a reset stops the scheduler from raising new requests.
  wire refreshOff = (partial_r == PAR_NONE) | ~rst_b;

  // ************************************************************
  // Refresh scheduler.
  // ************************************************************
  localparam int TMR_W = $clog2(INTERVAL_CYC + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(INTERVAL_CYC - 1);
  localparam logic [2:0] BUSY_LAST = 3'(REFRESH_BUSY_CYC - 1);

  rsc_rf_type state_r, state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [2:0] busy_r;
  logic [ROW_W-1:0] offs_r;
  logic extraLat_r;

  // The timer runs through waits and busy periods alike, so a held-back
  // refresh does not push every later one back with it.
  wire tick = (tmr_r == TMR_LAST);
  wire busyDone = (busy_r == BUSY_LAST);

  // The latency flag follows the scheduler at the moment select falls; the
  // strobe uses this next value so the first address cycle never shows the
  // flag left over from the previous access.
  wire latNxt = csFall ? (state_r != RF_IDLE) : extraLat_r;

  // Refresh starts only when no access is in progress.
  always_comb
  begin
    case (state_r)
      RF_IDLE: state_nxt = (tick && !refreshOff) ? RF_WAIT : RF_IDLE;
      // A pending request is dropped if the region is switched off while
      // it waits; a refresh already running is allowed to finish.
      RF_WAIT: state_nxt = refreshOff ? RF_IDLE
                         : accessActive ? RF_WAIT : RF_BUSY;
      RF_BUSY: state_nxt = busyDone ? RF_IDLE : RF_BUSY;
      default: state_nxt = RF_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_r <= RF_IDLE;
      tmr_r <= '0;
      busy_r <= '0;
      offs_r <= '0;
      extraLat_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r <= tick ? '0 : tmr_r + 1'b1;
      busy_r <= (state_r == RF_BUSY) ? busy_r + 1'b1 : '0;
      if (state_r == RF_BUSY && busyDone)
        offs_r <= (offs_r + 1'b1) & rowMask;
      // Latched at select fall so the whole address phase sees one value.
      extraLat_r <= latNxt;
    end
  end

  // ************************************************************
  // Registered outputs.
  // ************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      status <= '0;
      diffClkEn <= 1'b0;
      refreshRow <= '0;
      refreshStrobe <= 1'b0;
      read_write_data_strobe_o <= 1'b0;
      read_write_data_strobe_oe_b <= 1'b1;
    end
    else
    begin
      // The status word trails the fields by one cycle, so a write shows
      // one edge after it is taken.
      status.cfg <= {rsv_r, clkType_r, sleep_r, partial_r, intervalCode};
      status.sleeping <= sleep_r;
      status.refreshBusy <= (state_r == RF_BUSY);
      diffClkEn <= ~clkType_r;
      refreshRow <= rowBase | (offs_r & rowMask);
      refreshStrobe <= (state_r == RF_BUSY) && busyDone;
      // High means two latency periods; driven only during address phase.
      read_write_data_strobe_o <= apSync_r & latNxt;
      read_write_data_strobe_oe_b <= ~(apSync_r & accessActive);
    end
  end

  // ************************************************************
  // Link clock domain: differential clock qualification.
  // ************************************************************
  logic diffMeta_r, diffSync_r, invMeta_r, invSync_r, linkSample_r;

  logic linkRstMeta_b_r, linkRstSync_b_r;

  // Reset comes from the main clock, so it is re-timed through two link
  // flops; its release can then never land inside a link flop's window.
  // These two flops have no reset of their own by intent.
  always_ff @(posedge link_clk)
  begin
    linkRstMeta_b_r <= rst_b;
    linkRstSync_b_r <= linkRstMeta_b_r;
  end

  // Inverted clock is only looked at once differential mode has crossed.
  always_ff @(posedge link_clk)
  begin
    if (!linkRstSync_b_r)
    begin
      diffMeta_r <= 1'b0;
      diffSync_r <= 1'b0;
      invMeta_r <= 1'b0;
      invSync_r <= 1'b0;
      linkSample_r <= 1'b0;
    end
    else
    begin
      diffMeta_r <= diffClkEn;
      diffSync_r <= diffMeta_r;
      invMeta_r <= inverted_clock_input;
      invSync_r <= invMeta_r;
      linkSample_r <= diffSync_r ? ~invSync_r : 1'b1;
    end
  end

  // Bring the qualified level back to ref_clk.
  logic lsMeta_r;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      lsMeta_r <= 1'b0;
      linkClkSample <= 1'b0;
    end
    else
    begin
      lsMeta_r <= linkSample_r;
      linkClkSample <= lsMeta_r;
    end
  end

endmodule : rsc_refresh_sleep_config

// ===== rsc_pkg.sv
// Package for the refresh and sleep configuration block.
// Assumes a single 16-bit configuration word written by a decoded bus.
package rsc_pkg;

  // ************************************************************
  // Register layout and reset values.
  // ************************************************************
  localparam int CFG_W = 16;
  localparam int CLK_TYPE_BIT = 6;
  localparam int SLEEP_BIT = 5;
  localparam int PAR_HI = 4;
  localparam int PAR_LO = 2;
  localparam int INT_HI = 1;
  localparam int INT_LO = 0;
  localparam int RSV_LO = 7;
  localparam logic [8:0] RSV_RESET = 9'h1ff;
  localparam logic CLK_TYPE_RESET = 1'b1;
  localparam logic [2:0] PAR_RESET = 3'h0;

  // Refresh interval codes returned by the read-only field.
  localparam logic [1:0] INTERVAL_4US = 2'h1;
  localparam logic [1:0] INTERVAL_1US = 2'h2;

  // Partial refresh codes.
  localparam logic [2:0] PAR_FULL = 3'h0;
  localparam logic [2:0] PAR_NONE = 3'h4;

  // ************************************************************
  // Timing.
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int INTERVAL_4US_NS = 4000;
  localparam int INTERVAL_1US_NS = 1000;
  localparam int REFRESH_BUSY_CYC = 4;

  typedef struct packed {
    logic wrEn;
    logic [CFG_W-1:0] wrData;
  } rsc_wr_type;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic sleeping;
    logic refreshBusy;
  } rsc_stat_type;

endpackage : rsc_pkg

// ===== rsc_refresh_sleep_config_properties.sv
// Port checker for the refresh and sleep configuration block.
// Assumes it is bound to every instance of the block.
`timescale 1ns/1ps
module rsc_chk
  import rsc_pkg::*;
#(
  parameter bit HOT_PART = 1'b0,
  parameter int ROW_W = 8
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic chipSelect_b,
  input wire rsc_stat_type status,
  input wire logic diffClkEn,
  input wire logic linkClkSample,
  input wire logic [ROW_W-1:0] refreshRow,
  input wire logic refreshStrobe,
  input wire logic read_write_data_strobe_o,
  input wire logic read_write_data_strobe_oe_b
);
  // All checks run on the main clock and rest while reset is low.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire [2:0] par = status.cfg[4:2];

  a_clk_type_sel: assert property ($stable(status.cfg) [*3] |->
    diffClkEn == !status.cfg[6]) else $error("clock type wrong");
  a_single_ignores: assert property (!diffClkEn [*5] |->
    linkClkSample) else $error("inverted clock not ignored");
  a_select_wakes: assert property (status.sleeping &&
    $fell(chipSelect_b) |-> ##[1:6] !status.sleeping) else $error("no wake");
  a_interval_ro: assert property ($past(rst_b, 2) |->
    status.cfg[1:0] == (HOT_PART ? INTERVAL_1US : INTERVAL_4US))
    else $error("interval field wrong");
  a_none_quiet: assert property ((par == PAR_NONE) [*6] |->
    !refreshStrobe) else $error("refresh with none selected");
  a_region_side: assert property ($stable(status.cfg) [*8] ##0
    (refreshStrobe && par[1:0] != 2'h0) |-> refreshRow[ROW_W-1] == par[2])
    else $error("row outside region");
  a_wait_idle: assert property (!chipSelect_b [*5] |->
    !$rose(status.refreshBusy)) else $error("refresh during access");
  a_strobe_idle: assert property (chipSelect_b [*5] |->
    read_write_data_strobe_oe_b) else $error("strobe driven unselected");

  c_sleep: cover property (status.sleeping);
  c_refresh: cover property (refreshStrobe);
  c_latency: cover property (!read_write_data_strobe_oe_b &&
    read_write_data_strobe_o);
endmodule : rsc_chk

bind rsc_refresh_sleep_config rsc_chk #(.HOT_PART(HOT_PART),
  .ROW_W(ROW_W)) chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .chipSelect_b(chipSelect_b), .status(status), .diffClkEn(diffClkEn),
  .linkClkSample(linkClkSample), .refreshRow(refreshRow),
  .refreshStrobe(refreshStrobe),
  .read_write_data_strobe_o(read_write_data_strobe_o),
  .read_write_data_strobe_oe_b(read_write_data_strobe_oe_b));

// ===== rsc_host_model.sv
// Host controller model: select, address phase and inverted clock.
// Assumes callers enter access() just after a rising edge.
`timescale 1ns/1ps
module rsc_host_model
#(
  parameter int LIMIT = 40
)(
  input wire logic ref_clk,
  input wire logic rwdsO,
  input wire logic rwdsOeB,
  output logic chipSelect_b,
  output logic addrPhase,
  output logic invClk
);
  // The inverted clock is held at a level the bench picks.
  logic invLevel = 1'b0;
  assign invClk = invLevel;
  initial chipSelect_b = 1'b1;
  initial addrPhase = 1'b0;

  // One transfer; the strobe is read while the address phase stands.
  task automatic access(input int len, output logic lat, output logic drv);
    int n;
    n = (len < LIMIT - 10) ? len : LIMIT - 10;
    @(posedge ref_clk);
    chipSelect_b <= 1'b0;
    addrPhase <= 1'b1;
    repeat (7) @(posedge ref_clk);
    #1;
    lat = rwdsO;
    drv = !rwdsOeB;
    @(posedge ref_clk);
    addrPhase <= 1'b0;
    repeat (n) @(posedge ref_clk);
    chipSelect_b <= 1'b1;
  endtask : access
endmodule : rsc_host_model

// ===== rsc_refresh_sleep_config_tb_top.sv
// Bench: register, clock type, sleep, refresh and strobe scenarios.
// Assumes the host model owns select and address phase pins.
`timescale 1ns/1ps
module rsc_refresh_sleep_config_tb_top;
  import rsc_pkg::*;
  localparam int IV = 40;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  rsc_wr_type cfgWr = '0;
  rsc_stat_type status;
  logic diffClkEn, linkClk, rStb, rwdsO, rwdsOeB, csB, addr, inv, lat, drv;
  logic [7:0] row;
  int n_fail = 0;
  int checks = 0;
  int strobes = 0;
  int cyc = 0;
  int s;

  // Link clock is short so its phase drifts against the main clock.
  always #4 ref_clk = ~ref_clk;
  initial #1.3 forever #3 link_clk = ~link_clk;

  rsc_refresh_sleep_config #(.INTERVAL_CYC(IV)) dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .link_clk(link_clk), .inverted_clock_input(inv),
    .chipSelect_b(csB), .addrPhase(addr), .cfgWr(cfgWr), .status(status),
    .diffClkEn(diffClkEn), .linkClkSample(linkClk), .refreshRow(row),
    .refreshStrobe(rStb), .read_write_data_strobe_o(rwdsO),
    .read_write_data_strobe_oe_b(rwdsOeB));
  rsc_host_model #(.LIMIT(IV)) host (.ref_clk(ref_clk), .rwdsO(rwdsO),
    .rwdsOeB(rwdsOeB), .chipSelect_b(csB), .addrPhase(addr), .invClk(inv));

  // Counts refresh pulses and stops a hung run.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (rStb === 1'b1) strobes <= strobes + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic rst();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    // The count is taken once reset has settled, so a pulse launched just
    // before reset is not charged to the reset window.
    repeat (3) @(posedge ref_clk);
    s = strobes;
    repeat (13) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask : rst

  // Writes one word; status is settled on return.
  task automatic wr(input logic [15:0] d);
    @(posedge ref_clk);
    cfgWr <= '{1'b1, d};
    @(posedge ref_clk);
    cfgWr.wrEn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wr

  task automatic t_regs();
    chk(status.cfg, 16'hffc1);
    for (int p = 0; p < 8; p++)
    begin
      wr({11'h7fe, p[2:0], 2'h2});
      chk(status.cfg, {11'h7fe, p[2:0], 2'h1});
    end
    $display("regs done");
  endtask : t_regs

  task automatic t_clock();
    for (int m = 0; m < 2; m++)
      for (int lv = 0; lv < 2; lv++)
      begin
        wr(m ? 16'hffc1 : 16'hff81);
        @(posedge ref_clk);
        host.invLevel <= lv[0];
        repeat (6) @(negedge ref_clk);
        chk({14'h0, diffClkEn, linkClk}, {14'h0, !m[0], m[0] | !lv[0]});
      end
    $display("clock done");
  endtask : t_clock

  task automatic t_sleep();
    wr(16'hffe1);
    chk({15'h0, status.sleeping}, 16'h1);
    host.access(4, lat, drv);
    repeat (6) @(negedge ref_clk);
    chk({status.cfg[15:1], status.sleeping}, 16'hffc0);
    wr(16'hffe1);
    rst();
    chk({status.cfg[15:1], status.sleeping}, 16'hffc0);
    chk(16'(strobes - s), 16'h0);
    $display("sleep done");
  endtask : t_sleep

  // Long access holds back a refresh, the next access must see latency.
  task automatic t_refresh();
    wr(16'hffdd);
    wait (rStb === 1'b1);
    @(negedge ref_clk);
    chk({13'h0, row[7:5]}, 16'h7);
    // Let the counter take this pulse before the count is sampled.
    @(negedge ref_clk);
    s = strobes;
    host.access(IV, lat, drv);
    chk(16'(strobes - s), 16'h0);
    host.access(4, lat, drv);
    chk({14'h0, lat, drv}, 16'h3);
    wr(16'hffd1);
    s = strobes;
    repeat (100) @(negedge ref_clk);
    host.access(4, lat, drv);
    chk({14'h0, lat, drv}, {14'h0, 1'b0, 1'b1});
    chk(16'(strobes - s), 16'h0);
    $display("refresh done");
  endtask : t_refresh

  // Main sequence.
  initial
  begin
    rst();
    t_regs();
    t_clock();
    t_sleep();
    t_refresh();
    end_of_test();
  end
endmodule : rsc_refresh_sleep_config_tb_top
